/* core/buck_regulator_control_regs.sv */
`timescale 1ns/1ns
module buck_regulator_control_regs
	import buck_regs_pkg::*;
#(
	parameter int ADDR_W = 8, // byte address width
	parameter int CLK_MHZ = 10 // clock rate in MHz
) (
	input wire logic sys_clk, // system clock
	input wire logic srst, // synchronous reset, active high
	input wire wb_req_type wb_req, // wishbone request group
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire fuse_type fuse, // fuse array contents
	input wire logic regulator_enable, // second buck is enabled
	input wire logic ramp_active, // a voltage transition is in progress
	input wire logic ramp_falling, // the transition is downward
	output logic ramp_step_tick, // one pulse per 12.5 mV step
	output logic ramp_slow_select, // stored ramp-rate bit
	output logic force_ccm, // force continuous conduction
	output logic discharge_connect, // connect output discharge resistor
	output logic [1:0] current_limit_select, // current limit code
	output logic on_off_time_control_select, // 1 selects off-time control
	output logic [3:0] buck3_run_voltage_code, // third buck run code
	output logic [3:0] buck3_standby_voltage_code // third buck standby code
);

	localparam int FAST_CYC = RAMP_FAST_US * CLK_MHZ;
	localparam int SLOW_CYC = RAMP_SLOW_US * CLK_MHZ;

	// elaboration checks
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 8 and 32");
	end
	if (CLK_MHZ < 1 || SLOW_CYC > (1 << STEP_W)) begin : g_bad_clk
		$error("CLK_MHZ gives a step period the counter cannot hold");
	end

	state_type state_reg;
	state_type state_next;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = ADDR_W'({idx, 2'b00});
	endfunction

	// implemented bits of the register at a byte address, zero if unmapped
	function automatic logic [7:0] read_mask(input logic [ADDR_W-1:0] a);
		read_mask = 8'h00;
		if (a == reg_addr(IDX_BUCK2_CONTROL_UPPER)) begin
			read_mask = MASK_CONTROL_UPPER;
		end else if (a == reg_addr(IDX_BUCK2_CURRENT_LIMIT_TIMING)) begin
			read_mask = MASK_LIMIT_TIMING;
		end else if (a == reg_addr(IDX_BUCK3_RUN_VOLTAGE)) begin
			read_mask = MASK_CODE;
		end else if (a == reg_addr(IDX_BUCK3_STANDBY_VOLTAGE)) begin
			read_mask = MASK_CODE;
		end
	endfunction

	// step period minus one for a given ramp-rate bit
	function automatic logic [STEP_W-1:0] step_last(input logic slow);
		step_last = slow ? STEP_W'(SLOW_CYC - 1) : STEP_W'(FAST_CYC - 1);
	endfunction

	logic [ADDR_W-1:0] bus_addr;
	logic bus_req;
	logic bus_write;
	logic [7:0] wbyte;
	logic [7:0] rbyte;

	assign bus_addr = ADDR_W'(wb_req.adr);
	assign bus_req = wb_req.cyc && wb_req.stb;
	// a write lands at the edge where the master sees ack
	assign bus_write = bus_req && state_reg.ack && wb_req.we && wb_req.sel[0];
	assign wbyte = wb_req.dat[7:0];

	////////////////////////////////////////////////////////////////////////
	// read data assembly
	always_comb begin
		rbyte = 8'h00;
		if (bus_addr == reg_addr(IDX_BUCK2_CONTROL_UPPER)) begin
			rbyte[RAMP_RATE_BIT] = state_reg.ramp_rate;
			rbyte[FPWM_FALL_BIT] = state_reg.fpwm_fall;
			rbyte[FPWM_BIT] = state_reg.fpwm;
			rbyte[DIS_DISABLE_BIT] = state_reg.dis_disable;
		end else if (bus_addr == reg_addr(IDX_BUCK2_CURRENT_LIMIT_TIMING)) begin
			rbyte[ILIM_LSB +: 2] = state_reg.ilim;
			rbyte[TOFF_BIT] = state_reg.toff;
		end else if (bus_addr == reg_addr(IDX_BUCK3_RUN_VOLTAGE)) begin
			rbyte[CODE_LSB +: 4] = state_reg.run_code;
		end else if (bus_addr == reg_addr(IDX_BUCK3_STANDBY_VOLTAGE)) begin
			rbyte[CODE_LSB +: 4] = state_reg.stby_code;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.rdata = RST_DATA;
		case (state_reg.phase)
			PH_LOAD: begin
				// fuse load in the first cycle after reset
				state_next.ramp_rate = fuse.ramp_rate;
				state_next.dis_disable = fuse.discharge_disable;
				state_next.ilim = fuse.current_limit;
				state_next.run_code = fuse.run_code;
				state_next.stby_code = fuse.standby_code;
				state_next.src_sel = fuse.scaling_source_select;
				state_next.phase = PH_RUN;
			end
			PH_RUN: begin
				// software writes, only implemented bits are taken
				if (bus_write && bus_addr == reg_addr(IDX_BUCK2_CONTROL_UPPER)) begin
					state_next.ramp_rate = wbyte[RAMP_RATE_BIT];
					state_next.fpwm_fall = wbyte[FPWM_FALL_BIT];
					state_next.fpwm = wbyte[FPWM_BIT];
					state_next.dis_disable = wbyte[DIS_DISABLE_BIT];
				end
				if (bus_write && bus_addr == reg_addr(IDX_BUCK2_CURRENT_LIMIT_TIMING)) begin
					state_next.ilim = wbyte[ILIM_LSB +: 2];
					state_next.toff = wbyte[TOFF_BIT];
				end
			end
			default: begin
				state_next.phase = PH_LOAD;
			end
		endcase

		// single-cycle ack, read data captured with it
		if (bus_req && !state_reg.ack) begin
			state_next.ack = 1'b1;
			state_next.rdata = {24'h00_0000, rbyte};
		end

		// step timer runs only when this block paces the ramp
		state_next.step_tick = 1'b0;
		if (ramp_active && !state_reg.src_sel && state_reg.phase == PH_RUN) begin
			if (state_reg.step_cnt >= step_last(state_reg.ramp_rate)) begin
				state_next.step_cnt = STEP_ZERO;
				state_next.step_tick = 1'b1;
			end else begin
				state_next.step_cnt = state_reg.step_cnt + 1'b1;
			end
		end else begin
			state_next.step_cnt = STEP_ZERO;
		end

		// mode outputs to the power stage
		state_next.force_ccm = state_reg.fpwm
			|| (state_reg.fpwm_fall && ramp_active && ramp_falling);
		state_next.discharge_on = !state_reg.dis_disable && !regulator_enable;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg.phase <= PH_LOAD;
			state_reg.ramp_rate <= RST_BIT;
			state_reg.fpwm_fall <= RST_BIT;
			state_reg.fpwm <= RST_BIT;
			state_reg.dis_disable <= RST_BIT;
			state_reg.ilim <= RST_ILIM;
			state_reg.toff <= RST_BIT;
			state_reg.run_code <= RST_CODE;
			state_reg.stby_code <= RST_CODE;
			state_reg.src_sel <= RST_BIT;
			state_reg.ack <= RST_BIT;
			state_reg.rdata <= RST_DATA;
			state_reg.step_cnt <= STEP_ZERO;
			state_reg.step_tick <= RST_BIT;
			state_reg.force_ccm <= RST_BIT;
			state_reg.discharge_on <= RST_BIT;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign wb_dat_o = state_reg.rdata;
	assign wb_ack_o = state_reg.ack;
	assign ramp_step_tick = state_reg.step_tick;
	assign ramp_slow_select = state_reg.ramp_rate;
	assign force_ccm = state_reg.force_ccm;
	assign discharge_connect = state_reg.discharge_on;
	assign current_limit_select = state_reg.ilim;
	assign on_off_time_control_select = state_reg.toff;
	assign buck3_run_voltage_code = state_reg.run_code;
	assign buck3_standby_voltage_code = state_reg.stby_code;

	////////////////////////////////////////////////////////////////////////
	// checks

	ack_answer_a: assert property (@(posedge sys_clk) disable iff (srst)
		(bus_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack did not pulse one cycle after the request");

	unused_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
		wb_ack_o |-> ((wb_dat_o[7:0] & ~read_mask($past(bus_addr))) == 8'h00
			&& wb_dat_o[31:8] == 24'h00_0000))
		else $error("unused bits read back nonzero");

	fuse_load_a: assert property (@(posedge sys_clk) disable iff (srst)
		(state_reg.phase == PH_LOAD && !srst) |=> (ramp_slow_select == $past(fuse.ramp_rate)
			&& current_limit_select == $past(fuse.current_limit)
			&& state_reg.dis_disable == $past(fuse.discharge_disable)))
		else $error("fuse values not loaded after reset");

	ramp_write_a: assert property (@(posedge sys_clk) disable iff (srst)
		(state_reg.phase == PH_RUN && bus_write
			&& bus_addr == reg_addr(IDX_BUCK2_CONTROL_UPPER))
		|=> ramp_slow_select == $past(wbyte[RAMP_RATE_BIT])
			&& state_reg.fpwm == $past(wbyte[FPWM_BIT]))
		else $error("control write not stored");

	limit_write_a: assert property (@(posedge sys_clk) disable iff (srst)
		(state_reg.phase == PH_RUN && bus_write
			&& bus_addr == reg_addr(IDX_BUCK2_CURRENT_LIMIT_TIMING))
		|=> current_limit_select == $past(wbyte[1:0])
			&& on_off_time_control_select == $past(wbyte[TOFF_BIT]))
		else $error("current limit or timing select not stored");

	codes_fixed_a: assert property (@(posedge sys_clk) disable iff (srst)
		(state_reg.phase == PH_RUN && $past(state_reg.phase) == PH_RUN)
		|-> $stable(buck3_run_voltage_code) && $stable(buck3_standby_voltage_code))
		else $error("third buck code changed after load");

	step_period_a: assert property (@(posedge sys_clk) disable iff (srst)
		ramp_step_tick |-> $past(state_reg.step_cnt) == step_last($past(ramp_slow_select)))
		else $error("ramp step came at the wrong period");

	source_ignore_a: assert property (@(posedge sys_clk) disable iff (srst)
		state_reg.src_sel |=> !ramp_step_tick)
		else $error("step pacing active while fused source select is set");

	ccm_force_a: assert property (@(posedge sys_clk) disable iff (srst)
		force_ccm == $past(state_reg.fpwm
			|| (state_reg.fpwm_fall && ramp_active && ramp_falling)))
		else $error("forced conduction output wrong");

	discharge_map_a: assert property (@(posedge sys_clk) disable iff (srst)
		discharge_connect == $past(!state_reg.dis_disable && !regulator_enable))
		else $error("discharge resistor control wrong");

endmodule

/* core/buck_regs_pkg.sv */
package buck_regs_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_BUCK2_CONTROL_UPPER = 8'h3B;
	localparam logic [7:0] IDX_BUCK2_CURRENT_LIMIT_TIMING = 8'h3C;
	localparam logic [7:0] IDX_BUCK3_RUN_VOLTAGE = 8'h3E;
	localparam logic [7:0] IDX_BUCK3_STANDBY_VOLTAGE = 8'h3F;

	// field positions
	localparam int RAMP_RATE_BIT = 4;
	localparam int FPWM_FALL_BIT = 5;
	localparam int FPWM_BIT = 6;
	localparam int DIS_DISABLE_BIT = 7;
	localparam int ILIM_LSB = 0;
	localparam int TOFF_BIT = 4;
	localparam int CODE_LSB = 0;

	// implemented-bit masks per register
	localparam logic [7:0] MASK_CONTROL_UPPER = 8'hF0;
	localparam logic [7:0] MASK_LIMIT_TIMING = 8'h13;
	localparam logic [7:0] MASK_CODE = 8'h0F;

	// reset values; the fuse load right after reset overwrites the fused fields
	localparam logic RST_BIT = 1'b0;
	localparam logic [1:0] RST_ILIM = 2'h0;
	localparam logic [3:0] RST_CODE = 4'h0;
	localparam logic [31:0] RST_DATA = 32'h0000_0000;

	// ramp timing: one step per this many microseconds
	localparam int RAMP_FAST_US = 2;
	localparam int RAMP_SLOW_US = 4;
	localparam int STEP_W = 6;
	localparam logic [STEP_W-1:0] STEP_ZERO = 6'h00;

	typedef enum logic [1:0] {
		PH_LOAD = 2'b01,
		PH_RUN = 2'b10
	} phase_type;

	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} wb_req_type;

	typedef struct packed {
		logic ramp_rate;
		logic discharge_disable;
		logic [1:0] current_limit;
		logic [3:0] run_code;
		logic [3:0] standby_code;
		logic scaling_source_select;
	} fuse_type;

	typedef struct packed {
		phase_type phase;
		logic ramp_rate;
		logic fpwm_fall;
		logic fpwm;
		logic dis_disable;
		logic [1:0] ilim;
		logic toff;
		logic [3:0] run_code;
		logic [3:0] stby_code;
		logic src_sel;
		logic ack;
		logic [31:0] rdata;
		logic [STEP_W-1:0] step_cnt;
		logic step_tick;
		logic force_ccm;
		logic discharge_on;
	} state_type;

endpackage

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
	import buck_regs_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	wb_req_type req = '0;
	fuse_type fuse = '{1'b1, 1'b0, 2'h2, 4'hA, 4'h5, 1'b0};
	logic regulator_enable = 1'b1;
	logic ramp_active = 1'b0;
	logic ramp_falling = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, ramp_step_tick, ramp_slow_select, force_ccm, discharge_connect;
	logic [1:0] current_limit_select;
	logic on_off_time_control_select;
	logic [3:0] run_code, stby_code;
	logic [31:0] rd;
	int n_fail = 0;
	int n_tests = 0;
	localparam logic [7:0] A_CTL = {IDX_BUCK2_CONTROL_UPPER[5:0], 2'b00};
	localparam logic [7:0] A_LIM = {IDX_BUCK2_CURRENT_LIMIT_TIMING[5:0], 2'b00};
	localparam logic [7:0] A_RUN = {IDX_BUCK3_RUN_VOLTAGE[5:0], 2'b00};
	localparam logic [7:0] A_STB = {IDX_BUCK3_STANDBY_VOLTAGE[5:0], 2'b00};

	////////////////////////////////////////////////////////////////
	// clock, 100 ns period
	always #50 sys_clk = ~sys_clk;

	buck_regulator_control_regs dut_u (
		.sys_clk(sys_clk),
		.srst(srst),
		.wb_req(req),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.fuse(fuse),
		.regulator_enable(regulator_enable),
		.ramp_active(ramp_active),
		.ramp_falling(ramp_falling),
		.ramp_step_tick(ramp_step_tick),
		.ramp_slow_select(ramp_slow_select),
		.force_ccm(force_ccm),
		.discharge_connect(discharge_connect),
		.current_limit_select(current_limit_select),
		.on_off_time_control_select(on_off_time_control_select),
		.buck3_run_voltage_code(run_code),
		.buck3_standby_voltage_code(stby_code)
	);

	////////////////////////////////////////////////////////////////
	// verdict and run end
	task end_sim;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle, entered just after a rising edge; ends after one idle cycle
	task wb_cycle(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
		int i;
		req <= '{adr: a, dat: d, sel: s, we: w, cyc: 1'b1, stb: 1'b1};
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (wb_ack_o === 1'b1) break;
		end
		rd = wb_dat_o;
		req <= '0;
		if (i == 50) begin
			n_fail++;
			end_sim();
		end
		@(posedge sys_clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb_cycle(a, d, 1'b1, 4'hF);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb_cycle(a, 32'h0000_0000, 1'b0, 4'hF);
		chk(rd, exp);
	endtask

	// cycles between two step pulses
	task measure(input int exp);
		int i;
		int n;
		for (i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (ramp_step_tick === 1'b1) break;
		end
		for (n = 1; n < 100; n++) begin
			@(posedge sys_clk);
			if (ramp_step_tick === 1'b1) break;
		end
		chk(n, exp);
		// a missing pulse is a hang, so stop here
		if (i == 100 || n == 100) begin
			n_fail++;
			end_sim();
		end
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		int k;
		int cnt;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rdchk(A_CTL, 32'h0000_0010);
		rdchk(A_LIM, 32'h0000_0002);
		rdchk(A_RUN, 32'h0000_000A);
		rdchk(A_STB, 32'h0000_0005);
		wr(A_RUN, 32'h0000_00FF);
		wr(A_STB, 32'h0000_0000);
		rdchk(A_RUN, 32'h0000_000A);
		rdchk(A_STB, 32'h0000_0005);
		chk(run_code, 4'hA);
		chk(stby_code, 4'h5);
		// every control bit set, low nibble must stay empty
		wr(A_CTL, 32'h0000_00FF);
		rdchk(A_CTL, 32'h0000_00F0);
		regulator_enable <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(force_ccm, 1'b1);
		chk(ramp_slow_select, 1'b1);
		chk(discharge_connect, 1'b0);
		wr(A_CTL, 32'h0000_0000);
		rdchk(A_CTL, 32'h0000_0000);
		repeat (3) @(posedge sys_clk);
		chk(force_ccm, 1'b0);
		chk(discharge_connect, 1'b1);
		regulator_enable <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(discharge_connect, 1'b0);
		// forcing only while the target falls
		wr(A_CTL, 32'h0000_0020);
		ramp_active <= 1'b1;
		ramp_falling <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(force_ccm, 1'b1);
		ramp_falling <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(force_ccm, 1'b0);
		measure(RAMP_FAST_US * 10);
		wr(A_CTL, 32'h0000_0010);
		// falling target with the forcing bit clear must not force conduction
		ramp_falling <= 1'b1;
		measure(RAMP_SLOW_US * 10);
		chk(force_ccm, 1'b0);
		ramp_active <= 1'b0;
		// every limit code with both timing schemes, unused bits written high
		for (k = 0; k < 8; k++) begin
			wr(A_LIM, {24'h0, 3'h7, k[2], 2'h3, k[1:0]});
			rdchk(A_LIM, {24'h0, 3'h0, k[2], 2'h0, k[1:0]});
			chk(current_limit_select, k[1:0]);
			chk(on_off_time_control_select, k[2]);
		end
		wb_cycle(A_LIM, 32'h0000_0000, 1'b1, 4'hE);
		rdchk(A_LIM, 32'h0000_0013);
		wr(8'h00, 32'h0000_00FF);
		rdchk(8'h00, 32'h0000_0000);
		rdchk(8'hE8, 32'h0000_0000);
		// second reset with the fused scaling source selected
		srst <= 1'b1;
		fuse.scaling_source_select <= 1'b1;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rdchk(A_CTL, 32'h0000_0010);
		ramp_active <= 1'b1;
		cnt = 0;
		repeat (100) begin
			@(posedge sys_clk);
			if (ramp_step_tick !== 1'b0) cnt++;
		end
		chk(cnt, 0);
		end_sim();
	end
endmodule
